// ---- rtl/eos_pkg.sv ----
// package: register map, field layout and reset values for the termination block
package eos_pkg;
  localparam int          NUM_UNITS     = 4;
  localparam int          UNIT_W        = 2;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_TERM      = 12'h004;
  localparam logic [11:0] OFF_EOT       = 12'h008;
  localparam logic [11:0] OFF_PREV      = 12'h00C;
  localparam logic [11:0] OFF_XFER      = 12'h010;
  localparam logic [11:0] OFF_COUNT     = 12'h014;
  localparam logic [11:0] OFF_STATUS    = 12'h018;
  localparam logic [11:0] OFF_MASK      = 12'h01C;
  localparam logic [11:0] OFF_INIT      = 12'h020;
  localparam logic [11:0] OFF_DEFTERM   = 12'h024;
  localparam logic [11:0] OFF_DEFEOT    = 12'h028;
  // termination setting layout: low byte char, high byte methods
  localparam int          TERM_CHAR_LSB = 0;
  localparam int          BIT_RD_EOS    = 10;
  localparam int          BIT_WR_EOS    = 11;
  localparam int          BIT_CMP8      = 12;
  // control register fields
  localparam int          CTRL_BOARD    = 2;
  localparam int          CTRL_UNIT_LSB = 0;
  // transfer control fields
  localparam int          XFER_START    = 0;
  localparam int          XFER_WRITE    = 1;
  localparam int          XFER_BYTE_LSB = 8;
  localparam int          XFER_LEN_LSB  = 16;
  // status bits
  localparam int          ST_END        = 0;
  localparam int          ST_CMPL       = 1;
  localparam int          ST_BYTE       = 2;
  localparam int          ST_W          = 3;
  // reset values
  localparam logic [15:0] TERM_RESET    = 16'h0000;
  localparam logic        EOT_RESET     = 1'b1;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [31:0] RDATA_UNMAP   = 32'h0000_0000;
endpackage : eos_pkg

// ---- rtl/eos_match.sv ----
// module: compares a data byte with the configured end-of-string character
`timescale 1ns/100ps
module eos_match (
  input  wire logic       enable,
  input  wire logic       cmp8,
  input  wire logic [7:0] data,
  input  wire logic [7:0] eos_char,
  output logic            hit
);
  always_comb begin
    if (cmp8) begin
      hit = enable && (data == eos_char);
    end else begin
      hit = enable && (data[6:0] == eos_char[6:0]);
    end
  end
endmodule : eos_match

// ---- rtl/eos_setting_bank.sv ----
// module: per-unit and board termination settings with defaults restore
`timescale 1ns/100ps
module eos_setting_bank
  import eos_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  wr_term,
  input  wire logic                  wr_eot,
  input  wire logic                  init,
  input  wire logic                  sel_board,
  input  wire logic [UNIT_W-1:0]     sel_unit,
  input  wire logic [15:0]           wdata,
  input  wire logic [15:0]           def_term,
  input  wire logic                  def_eot,
  output logic      [15:0]           term,
  output logic                       eot
);
  logic [15:0] term_r [NUM_UNITS+1];
  logic [15:0] term_nxt [NUM_UNITS+1];
  logic        eot_r [NUM_UNITS+1];
  logic        eot_nxt [NUM_UNITS+1];
  logic [UNIT_W:0] idx;

  // board copy sits at the last index
  assign idx = sel_board ? (UNIT_W+1)'(NUM_UNITS) : {1'b0, sel_unit};
  assign term = term_r[idx];
  assign eot  = eot_r[idx];

  genvar g;
  generate
    for (g = 0; g <= NUM_UNITS; g++) begin : g_copy
      always_comb begin
        term_nxt[g] = term_r[g];
        eot_nxt[g]  = eot_r[g];
        if (init && idx == (UNIT_W+1)'(g)) begin
          term_nxt[g] = def_term;
          eot_nxt[g]  = def_eot;
        end else begin
          if (wr_term && idx == (UNIT_W+1)'(g)) term_nxt[g] = wdata;
          if (wr_eot && idx == (UNIT_W+1)'(g)) eot_nxt[g] = wdata[0];
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          term_r[g] <= TERM_RESET;
          eot_r[g]  <= EOT_RESET;
        end else begin
          term_r[g] <= term_nxt[g];
          eot_r[g]  <= eot_nxt[g];
        end
      end
    end
  endgenerate
endmodule : eos_setting_bank

// ---- rtl/eos_term_top.sv ----
// module: APB-controlled end-of-string and END termination for a data byte stream
//
// Functional notes
// - read ends on 7-bit character match
// - full-width option compares all eight bits
// - write asserts END on 7-bit character match
// - full-width option applies to write match
// - character low byte, method bits high byte
// - terminator never inserted into sent data
// - end-on-last-byte marks every final write byte
// - END shown on EOI during byte handshake
// - setting kept until rewritten or reinitialised
// - accepted setting returns previous value
// - separate settings per unit and board
// - match end sets END, reports count
`timescale 1ns/100ps
module eos_term_top
  import eos_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_EOI,
  output logic             RX_READY,
  output logic             TX_VALID,
  output logic [7:0]       TX_DATA,
  output logic             TX_EOI,
  input  wire logic        TX_ACK,
  output logic             IRQ
);
  import eos_pkg::*;

  // one-hot, so each state is a single flop; state tests still compare all three bits
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD   = 3'b010,
    ST_WR   = 3'b100
  } xfer_e;

  xfer_e       state_r, state_nxt;
  logic [2:0]  ctrl_r, ctrl_nxt;
  logic [15:0] prev_r, prev_nxt;
  logic [15:0] count_r, count_nxt;
  logic [15:0] len_r, len_nxt;
  logic [15:0] def_term_r, def_term_nxt;
  logic        def_eot_r, def_eot_nxt;
  logic [ST_W-1:0] status_r, status_nxt;
  logic [ST_W-1:0] mask_r, mask_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        rx_ready_r, rx_ready_nxt;
  logic        tx_valid_r, tx_valid_nxt;
  logic [7:0]  tx_data_r, tx_data_nxt;
  logic        tx_eoi_r, tx_eoi_nxt;
  logic        irq_r, irq_nxt;
  logic [7:0]  wbyte_r, wbyte_nxt;
  logic        wbyte_full_r, wbyte_full_nxt;

  // pins from outside the clock domain: two flip-flops before use
  // the peer holds data and EOI with valid, so the byte lands whole after two stages
  logic        rxv_s1, rxv_s2, rxe_s1, rxe_s2, ack_s1, ack_s2;
  logic [7:0]  rxd_s1, rxd_s2;

  logic        apb_acc, apb_wr, apb_rd;
  logic        wr_term, wr_eot, init_unit;
  logic [15:0] term;
  logic        eot;
  logic        rx_hit, tx_hit;
  logic        rx_take, tx_done;
  logic [ST_W-1:0] ev;
  logic        xfer_wr, byte_wr;
  logic        last_byte, rd_stop;
  logic        eoi_by_char, eoi_by_last;
  logic        wr_addr_ok;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rxv_s1 <= 1'b0;
      rxv_s2 <= 1'b0;
      rxe_s1 <= 1'b0;
      rxe_s2 <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      rxd_s1 <= 8'h00;
      rxd_s2 <= 8'h00;
    end else begin
      rxv_s1 <= RX_VALID;
      rxv_s2 <= rxv_s1;
      rxe_s1 <= RX_EOI;
      rxe_s2 <= rxe_s1;
      ack_s1 <= TX_ACK;
      ack_s2 <= ack_s1;
      rxd_s1 <= RX_DATA;
      rxd_s2 <= rxd_s1;
    end
  end

  // one-wait slave: registered PREADY answers in the cycle after the first access cycle
  assign apb_acc   = PSEL && PENABLE && !pready_r;
  assign apb_wr    = apb_acc && PWRITE;
  assign apb_rd    = apb_acc && !PWRITE;
  // term, EOT and init writes are ignored while a transfer runs; a CTRL write can still switch the copy in use
  assign wr_term   = apb_wr && PADDR == OFF_TERM && state_r == ST_IDLE;
  assign wr_eot    = apb_wr && PADDR == OFF_EOT && state_r == ST_IDLE;
  assign init_unit = apb_wr && PADDR == OFF_INIT && PWDATA[0] && state_r == ST_IDLE;

  // one bank holds every unit copy and the board copy
  eos_setting_bank u_bank (
    .clk       (SYS_CLK),
    .rst_n     (RESET_N),
    .wr_term   (wr_term),
    .wr_eot    (wr_eot),
    .init      (init_unit),
    .sel_board (ctrl_r[CTRL_BOARD]),
    .sel_unit  (ctrl_r[CTRL_UNIT_LSB +: UNIT_W]),
    .wdata     (PWDATA[15:0]),
    .def_term  (def_term_r),
    .def_eot   (def_eot_r),
    .term      (term),
    .eot       (eot)
  );

  // rx match sees the synchronised byte in the cycle it is taken
  eos_match u_rx_match (
    .enable   (term[BIT_RD_EOS]),
    .cmp8     (term[BIT_CMP8]),
    .data     (rxd_s2),
    .eos_char (term[TERM_CHAR_LSB +: 8]),
    .hit      (rx_hit)
  );

  // tx match looks at the queued byte, so EOI is known before the offer
  eos_match u_tx_match (
    .enable   (term[BIT_WR_EOS]),
    .cmp8     (term[BIT_CMP8]),
    .data     (wbyte_r),
    .eos_char (term[TERM_CHAR_LSB +: 8]),
    .hit      (tx_hit)
  );

  assign rx_take = state_r == ST_RD && rx_ready_r && rxv_s2;
  assign tx_done = state_r == ST_WR && tx_valid_r && ack_s2;

  // a start write may carry the first byte; later ones come with start low
  assign xfer_wr     = apb_wr && PADDR == OFF_XFER;
  assign byte_wr     = xfer_wr && PWDATA[XFER_WRITE] && !wbyte_full_r;
  // count_r counts finished bytes, so this marks the byte now in flight
  assign last_byte   = count_r + 16'h0001 == len_r;
  // talker EOI ends a read just as a terminator match does
  assign rd_stop     = rx_hit || rxe_s2;
  // the two END causes are kept apart so each can be traced alone
  assign eoi_by_char = tx_hit;
  assign eoi_by_last = eot && last_byte;
  // previous value and count are read-only; writes there are refused
  assign wr_addr_ok  = PADDR inside {OFF_CTRL, OFF_TERM, OFF_EOT, OFF_XFER, OFF_STATUS,
                                     OFF_MASK, OFF_INIT, OFF_DEFTERM, OFF_DEFEOT};

  always_comb begin
    state_nxt      = state_r;
    count_nxt      = count_r;
    len_nxt        = len_r;
    rx_ready_nxt   = rx_ready_r;
    tx_valid_nxt   = tx_valid_r;
    tx_data_nxt    = tx_data_r;
    tx_eoi_nxt     = tx_eoi_r;
    wbyte_nxt      = wbyte_r;
    wbyte_full_nxt = wbyte_full_r;
    // events are one-cycle pulses that feed the sticky status bits
    ev             = '0;
    if (byte_wr) begin
      // write data byte queued here; only host bytes are sent
      wbyte_nxt      = PWDATA[XFER_BYTE_LSB +: 8];
      wbyte_full_nxt = 1'b1;
    end
    case (state_r)
      ST_IDLE: begin
        if (xfer_wr && PWDATA[XFER_START]) begin
          count_nxt = COUNT_RESET;
          len_nxt   = PWDATA[XFER_LEN_LSB +: 16];
          if (PWDATA[XFER_WRITE]) begin
            state_nxt = ST_WR;
          end else begin
            state_nxt    = ST_RD;
            rx_ready_nxt = 1'b1;
          end
        end
      end
      ST_RD: begin
        if (rx_take) begin
          count_nxt = count_r + 16'h0001;
          // a full-length read reports CMPL only; END needs a terminator or EOI
          if (rd_stop || last_byte) begin
            state_nxt    = ST_IDLE;
            rx_ready_nxt = 1'b0;
            ev[ST_CMPL]  = 1'b1;
            ev[ST_END]   = rd_stop;
          end
        end
      end
      ST_WR: begin
        if (tx_done) begin
          tx_valid_nxt = 1'b0;
          tx_eoi_nxt   = 1'b0;
          count_nxt    = count_r + 16'h0001;
          ev[ST_BYTE]  = 1'b1;
          if (last_byte) begin
            state_nxt   = ST_IDLE;
            ev[ST_CMPL] = 1'b1;
          end
        end else if (!tx_valid_r && wbyte_full_r) begin
          // offer only with nothing in flight, so a byte never overtakes its ack
          tx_valid_nxt   = 1'b1;
          tx_data_nxt    = wbyte_r;
          wbyte_full_nxt = 1'b0;
          // EOI travels with the byte for its whole handshake
          tx_eoi_nxt     = eoi_by_char || eoi_by_last;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    ctrl_nxt     = ctrl_r;
    prev_nxt     = prev_r;
    def_term_nxt = def_term_r;
    def_eot_nxt  = def_eot_r;
    mask_nxt     = mask_r;
    // set wins over write-one-to-clear
    status_nxt   = status_r;
    if (apb_wr && PADDR == OFF_STATUS) status_nxt = status_r & ~PWDATA[ST_W-1:0];
    status_nxt   = status_nxt | ev;
    if (apb_wr) begin
      case (PADDR)
        OFF_CTRL:    ctrl_nxt     = PWDATA[2:0];
        OFF_MASK:    mask_nxt     = PWDATA[ST_W-1:0];
        OFF_DEFTERM: def_term_nxt = PWDATA[15:0];
        OFF_DEFEOT:  def_eot_nxt  = PWDATA[0];
        default:     ctrl_nxt     = ctrl_r;
      endcase
    end
    // the old copy is still on term in the cycle that the write lands
    if (wr_term) prev_nxt = term;
    if (wr_eot) prev_nxt = {15'h0000, eot};
    // irq follows the next status, so a clear drops it as soon as it lands
    irq_nxt     = |(status_nxt & mask_nxt);
    pready_nxt  = apb_acc;
    pslverr_nxt = 1'b0;
    // read data stands only with pready; other cycles show the unmapped value
    prdata_nxt  = RDATA_UNMAP;
    if (apb_rd) begin
      case (PADDR)
        OFF_CTRL:    prdata_nxt = {29'h0, ctrl_r};
        OFF_TERM:    prdata_nxt = {16'h0000, term};
        OFF_EOT:     prdata_nxt = {31'h0, eot};
        OFF_PREV:    prdata_nxt = {16'h0000, prev_r};
        OFF_XFER:    prdata_nxt = {len_r, 13'h0, state_r};
        OFF_COUNT:   prdata_nxt = {16'h0000, count_r};
        OFF_STATUS:  prdata_nxt = {29'h0, status_r};
        OFF_MASK:    prdata_nxt = {29'h0, mask_r};
        OFF_DEFTERM: prdata_nxt = {16'h0000, def_term_r};
        OFF_DEFEOT:  prdata_nxt = {31'h0, def_eot_r};
        default:     pslverr_nxt = 1'b1;
      endcase
    end else if (apb_wr) begin
      pslverr_nxt = !wr_addr_ok;
    end
  end

  // transfer group
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r      <= ST_IDLE;
      count_r      <= COUNT_RESET;
      len_r        <= 16'h0000;
      rx_ready_r   <= 1'b0;
      tx_valid_r   <= 1'b0;
      tx_data_r    <= 8'h00;
      tx_eoi_r     <= 1'b0;
      wbyte_r      <= 8'h00;
      wbyte_full_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      count_r      <= count_nxt;
      len_r        <= len_nxt;
      rx_ready_r   <= rx_ready_nxt;
      tx_valid_r   <= tx_valid_nxt;
      tx_data_r    <= tx_data_nxt;
      tx_eoi_r     <= tx_eoi_nxt;
      wbyte_r      <= wbyte_nxt;
      wbyte_full_r <= wbyte_full_nxt;
    end
  end

  // register group
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_r       <= 3'h0;
      prev_r       <= 16'h0000;
      def_term_r   <= TERM_RESET;
      def_eot_r    <= EOT_RESET;
      status_r     <= '0;
      mask_r       <= '0;
      prdata_r     <= 32'h0000_0000;
      pready_r     <= 1'b0;
      pslverr_r    <= 1'b0;
      irq_r        <= 1'b0;
    end else begin
      ctrl_r       <= ctrl_nxt;
      prev_r       <= prev_nxt;
      def_term_r   <= def_term_nxt;
      def_eot_r    <= def_eot_nxt;
      status_r     <= status_nxt;
      mask_r       <= mask_nxt;
      prdata_r     <= prdata_nxt;
      pready_r     <= pready_nxt;
      pslverr_r    <= pslverr_nxt;
      irq_r        <= irq_nxt;
    end
  end

  // every output is a register; no port is fed from logic
  assign PRDATA   = prdata_r;
  assign PREADY   = pready_r;
  assign PSLVERR  = pslverr_r;
  assign RX_READY = rx_ready_r;
  assign TX_VALID = tx_valid_r;
  assign TX_DATA  = tx_data_r;
  assign TX_EOI   = tx_eoi_r;
  assign IRQ      = irq_r;
endmodule : eos_term_top

// ---- dv/eos_term_top_asserts.sv ----
// checker: port timing of the termination block
`timescale 1ns/100ps
module eos_term_top_asserts (
  input wire logic       SYS_CLK,
  input wire logic       RESET_N,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PREADY,
  input wire logic       PSLVERR,
  input wire logic       TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic       TX_EOI,
  input wire logic       TX_ACK,
  input wire logic       RX_READY,
  input wire logic       IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_acked;
    TX_ACK [*2];
  endsequence
  property p_rdy_answer; s_access |=> PREADY; endproperty
  property p_rdy_pulse; PREADY |=> !PREADY; endproperty
  property p_rdy_cause; PREADY |-> $past(PSEL && PENABLE); endproperty
  property p_err_rdy; PSLVERR |-> PREADY; endproperty
  property p_tx_hold; (TX_VALID && !TX_ACK) [*4] |=> TX_VALID; endproperty
  property p_tx_stable; TX_VALID && $past(TX_VALID) |-> $stable(TX_DATA) && $stable(TX_EOI); endproperty
  property p_tx_release; s_acked |-> ##[1:4] !TX_VALID; endproperty
  property p_reset_quiet; $rose(RESET_N) |-> !TX_VALID && !IRQ && !PREADY && !RX_READY; endproperty
  a_rdy_answer: assert property (p_rdy_answer)
    else $error("ready missing after access");
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready longer than one cycle");
  a_rdy_cause: assert property (p_rdy_cause)
    else $error("ready without access");
  a_err_rdy: assert property (p_err_rdy)
    else $error("error without ready");
  a_tx_hold: assert property (p_tx_hold)
    else $error("byte withdrawn before ack");
  a_tx_stable: assert property (p_tx_stable)
    else $error("byte or end flag changed while offered");
  a_tx_release: assert property (p_tx_release)
    else $error("byte not withdrawn after ack");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active right after reset");
endmodule : eos_term_top_asserts

// ---- dv/eos_peer.sv ----
// partner model: instrument on the far side of the byte link
`timescale 1ns/100ps
module eos_peer (
  input  wire logic       clk,
  input  wire logic       tx_valid,
  output logic            tx_ack,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_eoi
);
  int ack_wait = 0;
  initial begin
    tx_ack = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'hFF;
    rx_eoi = 1'b0;
  end
  // one valid cycle per byte; the data lines never keep a stale byte afterwards
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    repeat (3) @(posedge clk);
  endtask : send_byte
  // full handshake: ack held until the byte is withdrawn, delay set by the bench
  always begin
    @(posedge clk);
    if (tx_valid && !tx_ack) begin
      repeat (ack_wait) @(posedge clk);
      tx_ack <= 1'b1;
      while (tx_valid) @(posedge clk);
      tx_ack <= 1'b0;
    end
  end
endmodule : eos_peer

// ---- dv/tb.sv ----
// testbench: register and byte-link tests of the termination block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  import eos_pkg::*;
  logic        SYS_CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        RX_VALID, RX_EOI, RX_READY, TX_VALID, TX_EOI, TX_ACK, IRQ;
  logic [7:0]  RX_DATA, TX_DATA;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [15:0] lfsr = 16'h004B;
  logic [32:0] rd_q[$];
  logic [8:0]  tx_q[$];
  logic [32:0] rde;
  logic [8:0]  txe;
  eos_term_top i_dut (.*);
  eos_peer i_peer (.clk(SYS_CLK), .tx_valid(TX_VALID), .tx_ack(TX_ACK), .rx_valid(RX_VALID),
                   .rx_data(RX_DATA), .rx_eoi(RX_EOI));
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) rd_q.push_back(e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (!PREADY);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd
  always @(posedge SYS_CLK) begin
    if (PSEL && PENABLE && PREADY && !PWRITE) begin
      rde = rd_q.size() ? rd_q.pop_front() : 33'h1FFFFFFFF;
      `CHK("PRDATA", rde, {PSLVERR, PRDATA})
    end
    if ($rose(TX_VALID)) begin
      txe = tx_q.size() ? tx_q.pop_front() : 9'h1FF;
      `CHK("TX", txe, {TX_EOI, TX_DATA})
    end
  end
  // ends a read after the second byte if x is a terminator match
  task automatic rx_run(input logic [15:0] term, input logic [7:0] x);
    logic hit;
    hit = term[10] && (term[12] ? x == term[7:0] : x[6:0] == term[6:0]);
    wr(OFF_TERM, 32'(term));
    wr(OFF_XFER, {16'd4, 16'h0001});
    `CHK("RX_READY", 1'b1, RX_READY)
    for (int i = 0; i < 4; i++) begin
      if (RX_READY) i_peer.send_byte(i == 1 ? x : 8'h41 + 8'(i));
    end
    while (RX_READY) @(posedge SYS_CLK);
    rd(OFF_COUNT, hit ? 32'd2 : 32'd4);
    rd(OFF_STATUS, {30'h0, 1'b1, hit});
    wr(OFF_STATUS, 32'h7);
    $display("read test done");
  endtask : rx_run
  // the host supplies every byte, terminator included
  task automatic tx_run(input logic [15:0] term, input logic eot, input int n);
    logic [7:0] b;
    logic       hit;
    wr(OFF_TERM, 32'(term));
    wr(OFF_EOT, 32'(eot));
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_next(lfsr);
      b = i == 1 ? term[7:0] ^ 8'h80 : (i == 2 ? term[7:0] : lfsr[7:0]);
      hit = term[12] ? b == term[7:0] : b[6:0] == term[6:0];
      tx_q.push_back({(term[11] && hit) || (eot && i == n - 1), b});
      // the first byte rides on the start write; byte lane is bits 15:8
      wr(OFF_XFER, {16'(n), b, (i == 0) ? 8'h03 : 8'h02});
      while (!TX_VALID) @(posedge SYS_CLK);
      while (TX_VALID) @(posedge SYS_CLK);
    end
    $display("write test done");
  endtask : tx_run
  initial begin
    RESET_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    repeat (4) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    rd(OFF_EOT, 32'(EOT_RESET));
    wr(OFF_CTRL, 32'h1);
    wr(OFF_TERM, 32'h040A);
    wr(OFF_TERM, 32'h140A);
    rd(OFF_PREV, 32'h040A);
    wr(OFF_CTRL, 32'h2);
    rd(OFF_TERM, 32'h0);
    wr(OFF_CTRL, 32'h4);
    rd(OFF_TERM, 32'h0);
    wr(OFF_CTRL, 32'h1);
    rd(OFF_TERM, 32'h140A);
    wr(OFF_DEFTERM, 32'h0C0D);
    wr(OFF_INIT, 32'h1);
    rd(OFF_TERM, 32'h0C0D);
    $display("settings test done");
    rx_run(16'h040A, 8'h8A);
    rx_run(16'h140A, 8'h8A);
    rx_run(16'h000A, 8'h0A);
    rx_run(16'h140A, 8'h0A);
    tx_run(16'h080A, 1'b0, 5);
    i_peer.ack_wait = 6;
    tx_run(16'h180A, 1'b0, 5);
    tx_run(16'h0000, 1'b1, 4);
    tx_run(16'h080A, 1'b1, 6);
    wr(OFF_MASK, 32'h0);
    `CHK("IRQ", 1'b0, IRQ)
    wr(OFF_MASK, 32'h2);
    `CHK("IRQ", 1'b1, IRQ)
    wr(OFF_STATUS, 32'h2);
    `CHK("IRQ", 1'b0, IRQ)
    apb(1'b0, 12'h100, 32'h0, {1'b1, RDATA_UNMAP});
    `CHK("TX left", 0, tx_q.size())
    $display("interrupt test done");
    end_sim();
  end
endmodule : tb
bind eos_term_top eos_term_top_asserts i_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
  .TX_EOI(TX_EOI), .TX_ACK(TX_ACK), .RX_READY(RX_READY), .IRQ(IRQ));
